// ### rtl/rsw_pkg.sv
// package of constants for the reset, stop and wait sequencer
// assumes a single 125 MHz core clock and an external oscillator sampled as a level
package rsw_pkg;

   // ---------------------------------------------------------------
   // clock and timing figures
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int FIRST_ADDR_MAX_T = 120;  // reset release to first address, core cycles
   localparam int ISR_ACCESS_MAX_T = 18;   // interrupt to first service access, core cycles
   localparam int WAIT_VECTOR_MAX_T = 13;  // interrupt a low to vector out from wait
   localparam int STOP_HOLD_FAST_T = 4;    // interrupt a hold to leave fast stop
   localparam int STOP_HOLD_NORMAL_ET = 8; // interrupt a hold to leave normal stop
   localparam int STOP_FETCH_FAST_T = 13;  // interrupt a to first fetch, fast stop
   localparam int STOP_FETCH_NORMAL_ET = 25; // interrupt a to first fetch, normal stop
   localparam int RESET_OUT_NORMAL_ET = 128;
   localparam int RESET_OUT_INTERNAL_ET = 8;

   // derived counts; each event is flagged one cycle after the count matches,
   // and input sampling costs one more, hence the margins
   localparam logic [7:0] FIRST_ADDR_CYC = 8'(FIRST_ADDR_MAX_T - 2);
   localparam logic [7:0] ISR_ACCESS_CYC = 8'(ISR_ACCESS_MAX_T - 3);
   localparam logic [7:0] WAIT_VECTOR_CYC = 8'(WAIT_VECTOR_MAX_T - 3);
   localparam logic [7:0] STOP_HOLD_FAST_CYC = 8'(STOP_HOLD_FAST_T);
   localparam logic [7:0] STOP_HOLD_NORMAL_TICKS = 8'(STOP_HOLD_NORMAL_ET);
   localparam logic [7:0] STOP_FETCH_FAST_CYC = 8'(STOP_FETCH_FAST_T - STOP_HOLD_FAST_T - 3);
   localparam logic [7:0] STOP_FETCH_NORMAL_TICKS = 8'(STOP_FETCH_NORMAL_ET - STOP_HOLD_NORMAL_ET - 3);
   localparam logic [7:0] RESET_OUT_NORMAL_TICKS = 8'(RESET_OUT_NORMAL_ET);
   localparam logic [7:0] RESET_OUT_INTERNAL_TICKS = 8'(RESET_OUT_INTERNAL_ET);

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_MODE = 4'h0;   // operating_mode_register
   localparam logic [3:0] ADDR_CMD = 4'h1;    // wait and stop requests, write only
   localparam logic [3:0] ADDR_STATUS = 4'h2; // sticky events, cleared by read
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [3:0] ADDR_STATE = 4'h4;  // sequencer state and clock controls

   // operating_mode_register fields
   localparam int MODE_SEL_LSB = 0;       // two bits, chip operating mode
   localparam int MODE_INT_RESET_BIT = 2; // short reset output pulse
   localparam int MODE_PLL_REQ_BIT = 3;   // software wants the clock multiplier
   localparam int MODE_FAST_STOP_BIT = 6;
   localparam logic [1:0] MODE_PINS_VISIBLE = 2'h3;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam logic [15:0] MODE_WRITE_MASK = 16'h004F;

   // command fields
   localparam int CMD_WAIT_BIT = 0;
   localparam int CMD_STOP_BIT = 1;

   // status and mask fields
   localparam int EV_FIRST_ADDR = 0;
   localparam int EV_ISR_ACCESS = 1;
   localparam int EV_WAIT_WAKE = 2;
   localparam int EV_STOP_WAKE = 3;
   localparam int EV_RESET_OUT_DONE = 4;
   localparam int EV_COUNT = 5;
   localparam logic [4:0] EV_RESET = 5'h00;

   // sequencer states
   typedef enum logic [3:0] {
      ST_BOOT,
      ST_RUN,
      ST_ISR,
      ST_WAIT,
      ST_WAIT_VEC,
      ST_STOP,
      ST_RESTART,
      ST_FETCH
   } rsw_state_type;

endpackage

// ### rtl/rsw_reset_out.sv
// reset output pulse timer, counting external oscillator periods
// assumes ext_tick_i is a one-cycle pulse per oscillator period
`timescale 1ns/1ns
module rsw_reset_out
   import rsw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // control
   input wire logic start_i,
   input wire logic ext_tick_i,
   input wire logic internal_mode_i,
   // pulse
   output logic reset_out_pulse_n_o,
   output logic done_o
);

   logic active;
   logic [7:0] count;
   logic done;
   logic next_active;
   logic [7:0] next_count;
   logic next_done;
   logic [7:0] terminal;

   // -----------------------------------------------------------------
   // width selection and counting
   // -----------------------------------------------------------------
   // terminal count follows the reset mode selection
   always_comb
   begin
      terminal = internal_mode_i ? RESET_OUT_INTERNAL_TICKS : RESET_OUT_NORMAL_TICKS;
      next_active = active;
      next_count = count;
      next_done = 1'b0;
      if (start_i)
      begin
         next_active = 1'b1;
         next_count = 8'h00;
      end
      else if (active && ext_tick_i)
      begin
         if (count == terminal - 8'h01)
         begin
            next_active = 1'b0;
            next_done = 1'b1;
         end
         next_count = count + 8'h01;
      end
   end

   // pulse starts at reset so the output is low from power up
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         active <= 1'b1;
         count <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         active <= next_active;
         count <= next_count;
         done <= next_done;
      end
   end

   assign reset_out_pulse_n_o = ~active;
   assign done_o = done;

endmodule

// ### rtl/rsw_sequencer.sv
// reset, wait and stop sequencer with its register port
// assumes interrupt and oscillator inputs synchronous to sys_clk_i
// Function
// - after reset release the first external address is put out within 120 core cycles.
// - reset turns the clock multiplier off and bypasses it so the core runs from the source clock.
// - the first service-routine access or output change follows either interrupt within 18 cycles.
// - waking from wait on interrupt a puts out the vector address within 13 cycles.
// - with mode bit 6 set, stop keeps multiplier and clock running and skips the restart period.
// - normal stop disables and bypasses the multiplier, gates the clock and spends one oscillator period restarting it.
// - leaving stop fetches within 13 core cycles (fast) or 25 oscillator periods (normal).
// - the reset output lasts 128 oscillator periods, or 8 in internal reset mode.
// - the stop recovery fetch shows on the pins only in operating mode 3.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module rsw_sequencer
   import rsw_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // external pins
   input wire logic ext_osc_i,
   input wire logic ext_interrupt_a_n_i,
   input wire logic ext_interrupt_b_n_i,
   input wire logic internal_reset_req_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [15:0] reg_rdata_o,
   // sequencing events
   output logic first_addr_o,
   output logic isr_access_o,
   output logic wait_vector_o,
   output logic stop_fetch_o,
   output logic stop_fetch_pins_o,
   // clock control
   output logic pll_enable_o,
   output logic pll_bypass_o,
   output logic master_clk_en_o,
   // reset output and interrupt
   output logic reset_out_pulse_n_o,
   output logic irq_o
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   rsw_state_type state, next_state;
   logic [7:0] cnt, next_cnt;
   logic pll_enable, next_pll_enable, pll_bypass, next_pll_bypass, clk_en, next_clk_en;
   logic first_addr, next_first_addr, isr_access, next_isr_access;
   logic wait_vector, next_wait_vector, stop_fetch, next_stop_fetch;
   logic stop_fetch_pins, next_stop_fetch_pins, fast_stop, next_fast_stop;
   logic [15:0] operating_mode_register, next_operating_mode_register, rdata, next_rdata;
   logic [EV_COUNT-1:0] status, next_status, mask, next_mask, events;
   logic irq_a_prev, irq_b_prev, osc_prev, ext_tick, fall_a, fall_b, irq_a_low;
   logic wait_req, stop_req, rst_out_done, rst_out_start;

   // -----------------------------------------------------------------
   // input edges
   // -----------------------------------------------------------------
   // one oscillator period is one rising edge of the sampled oscillator
   assign ext_tick = ext_osc_i & ~osc_prev;
   assign fall_a = irq_a_prev & ~ext_interrupt_a_n_i;
   assign fall_b = irq_b_prev & ~ext_interrupt_b_n_i;
   assign irq_a_low = ~ext_interrupt_a_n_i;
   assign wait_req = reg_write_i && (reg_addr_i == ADDR_CMD) && reg_wdata_i[CMD_WAIT_BIT];
   assign stop_req = reg_write_i && (reg_addr_i == ADDR_CMD) && reg_wdata_i[CMD_STOP_BIT];
   assign rst_out_start = internal_reset_req_i;

   // previous input levels for edge detection
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         irq_a_prev <= 1'b1;
         irq_b_prev <= 1'b1;
         osc_prev <= 1'b0;
      end
      else
      begin
         irq_a_prev <= ext_interrupt_a_n_i;
         irq_b_prev <= ext_interrupt_b_n_i;
         osc_prev <= ext_osc_i;
      end
   end

   // -----------------------------------------------------------------
   // reset output pulse
   // -----------------------------------------------------------------
   rsw_reset_out u_reset_out (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .start_i(rst_out_start),
      .ext_tick_i(ext_tick),
      .internal_mode_i(operating_mode_register[MODE_INT_RESET_BIT]),
      .reset_out_pulse_n_o(reset_out_pulse_n_o),
      .done_o(rst_out_done)
   );

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   // boot, run, service, wait and stop sequencing with clock controls
   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 8'h01;
      next_pll_enable = pll_enable;
      next_pll_bypass = pll_bypass;
      next_clk_en = clk_en;
      next_fast_stop = fast_stop;
      next_first_addr = 1'b0;
      next_isr_access = 1'b0;
      next_wait_vector = 1'b0;
      next_stop_fetch = 1'b0;
      next_stop_fetch_pins = 1'b0;
      unique case (state)
         ST_BOOT:
         begin
            if (cnt == FIRST_ADDR_CYC)
            begin
               next_first_addr = 1'b1;
               next_state = ST_RUN;
               next_cnt = 8'h00;
            end
         end
         ST_RUN:
         begin
            next_cnt = 8'h00;
            // multiplier follows software only while running
            next_pll_enable = operating_mode_register[MODE_PLL_REQ_BIT];
            next_pll_bypass = ~operating_mode_register[MODE_PLL_REQ_BIT];
            if (fall_a || fall_b)
               next_state = ST_ISR;
            else if (stop_req)
            begin
               next_fast_stop = operating_mode_register[MODE_FAST_STOP_BIT];
               if (!operating_mode_register[MODE_FAST_STOP_BIT])
               begin
                  next_pll_enable = 1'b0;
                  next_pll_bypass = 1'b1;
                  next_clk_en = 1'b0;
               end
               next_state = ST_STOP;
            end
            else if (wait_req)
               next_state = ST_WAIT;
         end
         ST_ISR:
         begin
            if (cnt == ISR_ACCESS_CYC)
            begin
               next_isr_access = 1'b1;
               next_state = ST_RUN;
            end
         end
         ST_WAIT:
         begin
            next_cnt = 8'h00;
            if (fall_a)
               next_state = ST_WAIT_VEC;
            else if (fall_b)
               next_state = ST_ISR;
         end
         ST_WAIT_VEC:
         begin
            if (cnt == WAIT_VECTOR_CYC)
            begin
               next_wait_vector = 1'b1;
               next_state = ST_RUN;
            end
         end
         ST_STOP:
         begin
            // hold time of interrupt a counted in cycles or oscillator periods
            if (!irq_a_low)
               next_cnt = 8'h00;
            else if (fast_stop)
            begin
               if (cnt == STOP_HOLD_FAST_CYC - 8'h01)
               begin
                  next_state = ST_FETCH;
                  next_cnt = 8'h00;
               end
            end
            else if (ext_tick)
            begin
               if (cnt == STOP_HOLD_NORMAL_TICKS - 8'h01)
               begin
                  next_state = ST_RESTART;
                  next_cnt = 8'h00;
               end
            end
            else
               next_cnt = cnt;
         end
         ST_RESTART:
         begin
            // extra period to restart the gated clock
            next_cnt = 8'h00;
            if (ext_tick)
            begin
               next_clk_en = 1'b1;
               next_state = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            if (!fast_stop && !ext_tick)
               next_cnt = cnt;
            if ((fast_stop && cnt == STOP_FETCH_FAST_CYC) ||
                (!fast_stop && ext_tick && cnt == STOP_FETCH_NORMAL_TICKS))
            begin
               next_stop_fetch = 1'b1;
               next_stop_fetch_pins = (operating_mode_register[MODE_SEL_LSB +: 2] == MODE_PINS_VISIBLE);
               next_state = ST_RUN;
               next_cnt = 8'h00;
            end
         end
      endcase
      // an internal reset restarts the boot sequence from the source clock
      if (internal_reset_req_i)
      begin
         next_state = ST_BOOT;
         next_cnt = 8'h00;
         next_pll_enable = 1'b0;
         next_pll_bypass = 1'b1;
         next_clk_en = 1'b1;
      end
   end

   // sequencer registers; multiplier off and bypassed out of reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= ST_BOOT;
         cnt <= 8'h00;
         pll_enable <= 1'b0;
         pll_bypass <= 1'b1;
         clk_en <= 1'b1;
         fast_stop <= 1'b0;
         first_addr <= 1'b0;
         isr_access <= 1'b0;
         wait_vector <= 1'b0;
         stop_fetch <= 1'b0;
         stop_fetch_pins <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         pll_enable <= next_pll_enable;
         pll_bypass <= next_pll_bypass;
         clk_en <= next_clk_en;
         fast_stop <= next_fast_stop;
         first_addr <= next_first_addr;
         isr_access <= next_isr_access;
         wait_vector <= next_wait_vector;
         stop_fetch <= next_stop_fetch;
         stop_fetch_pins <= next_stop_fetch_pins;
      end
   end

   // -----------------------------------------------------------------
   // registers and interrupt
   // -----------------------------------------------------------------
   assign events = {rst_out_done, next_stop_fetch, next_wait_vector, next_isr_access, next_first_addr};

   // writes, read-clear of status with set winning, read data
   always_comb
   begin
      next_operating_mode_register = operating_mode_register;
      next_mask = mask;
      next_status = status;
      next_rdata = 16'h0000;
      if (reg_write_i && reg_addr_i == ADDR_MODE)
         next_operating_mode_register = reg_wdata_i & MODE_WRITE_MASK;
      if (reg_write_i && reg_addr_i == ADDR_MASK)
         next_mask = reg_wdata_i[EV_COUNT-1:0];
      if (reg_read_i)
      begin
         unique case (reg_addr_i)
            ADDR_MODE: next_rdata = operating_mode_register;
            ADDR_STATUS: next_rdata = {11'h000, status};
            ADDR_MASK: next_rdata = {11'h000, mask};
            ADDR_STATE: next_rdata = {9'h000, clk_en, pll_bypass, pll_enable, 4'(state)};
            default: next_rdata = 16'h0000;
         endcase
         if (reg_addr_i == ADDR_STATUS)
            next_status = '0;
      end
      next_status = next_status | events;
   end

   // register file flops
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         operating_mode_register <= MODE_RESET;
         mask <= EV_RESET;
         status <= EV_RESET;
         rdata <= 16'h0000;
      end
      else
      begin
         operating_mode_register <= next_operating_mode_register;
         mask <= next_mask;
         status <= next_status;
         rdata <= next_rdata;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign reg_rdata_o = rdata;
   assign irq_o = |(status & mask);
   assign first_addr_o = first_addr;
   assign isr_access_o = isr_access;
   assign wait_vector_o = wait_vector;
   assign stop_fetch_o = stop_fetch;
   assign stop_fetch_pins_o = stop_fetch_pins;
   assign pll_enable_o = pll_enable;
   assign pll_bypass_o = pll_bypass;
   assign master_clk_en_o = clk_en;

endmodule

// ### verif/rsw_far_model.sv
// far-side model: free-running oscillator, interrupt senders, reset request
// assumes the bench calls one task at a time, between clock edges
`timescale 1ns/1ns
module rsw_far_model
(
   // clock
   input wire logic sys_clk_i,
   // pins toward the sequencer
   output logic ext_osc_o,
   output logic irq_a_n_o,
   output logic irq_b_n_o,
   output logic reset_req_o
);
   // oscillator runs free: two cycles high, two low, one period is four core cycles
   initial
   begin
      ext_osc_o = 1'b0;
      irq_a_n_o = 1'b1;
      irq_b_n_o = 1'b1;
      reset_req_o = 1'b0;
      forever
      begin
         repeat (2) @(posedge sys_clk_i);
         ext_osc_o <= ~ext_osc_o;
      end
   end

   // edge request held two cycles, well past one cycle plus 3 ns
   task automatic edge_irq(input logic line_b);
      @(posedge sys_clk_i);
      if (line_b)
         irq_b_n_o <= 1'b0;
      else
         irq_a_n_o <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      irq_a_n_o <= 1'b1;
      irq_b_n_o <= 1'b1;
   endtask

   // level on line a, the caller keeps it low through stop recovery
   task automatic set_a(input logic lvl);
      @(posedge sys_clk_i);
      irq_a_n_o <= lvl;
   endtask

   // one-cycle internal reset request
   task automatic pulse_rst();
      @(posedge sys_clk_i);
      reset_req_o <= 1'b1;
      @(posedge sys_clk_i);
      reset_req_o <= 1'b0;
   endtask
endmodule

// ### verif/rsw_sequencer_chk.sv
// timing relations between the sequencer's causes and its events
// assumes it is bound into rsw_sequencer, single clock domain
`timescale 1ns/1ns
module rsw_sequencer_chk
   import rsw_pkg::*;
(
   // clock, reset and pins
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic ext_osc_i,
   input wire logic ext_interrupt_a_n_i,
   input wire logic ext_interrupt_b_n_i,
   input wire logic internal_reset_req_i,
   input wire logic reg_read_i,
   input wire logic [15:0] reg_rdata_o,
   // watched outputs
   input wire logic first_addr_o,
   input wire logic isr_access_o,
   input wire logic wait_vector_o,
   input wire logic stop_fetch_o,
   input wire logic stop_fetch_pins_o,
   input wire logic pll_enable_o,
   input wire logic pll_bypass_o,
   input wire logic master_clk_en_o,
   input wire logic reset_out_pulse_n_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic a_q, b_q, osc_q, a_fall, any_fall, tick, gated, next_gated;
   logic [7:0] boot_cnt, irq_cnt, a_cnt, a_ticks, lo_ticks;
   logic [7:0] next_boot_cnt, next_irq_cnt, next_a_cnt, next_a_ticks, next_lo_ticks;

   // counts of cycles and oscillator ticks since each cause, saturating except the reset output low-time tick count
   always_comb
   begin
      a_fall = a_q & ~ext_interrupt_a_n_i;
      any_fall = a_fall | (b_q & ~ext_interrupt_b_n_i);
      tick = ~osc_q & ext_osc_i;
      next_boot_cnt = internal_reset_req_i ? 8'h00 : boot_cnt + 8'(boot_cnt != 8'hFF);
      next_irq_cnt = any_fall ? 8'h01 : irq_cnt + 8'(irq_cnt != 8'hFF);
      next_a_cnt = a_fall ? 8'h01 : a_cnt + 8'(a_cnt != 8'hFF);
      next_a_ticks = a_fall ? 8'h00 : a_ticks + 8'(tick && a_ticks != 8'hFF);
      next_lo_ticks = reset_out_pulse_n_o ? 8'h00 : lo_ticks + 8'(tick);
      next_gated = !master_clk_en_o || (gated && !stop_fetch_o);
   end

   // registers of the counters and the previous pin levels
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         a_q <= 1'b1;
         b_q <= 1'b1;
         osc_q <= 1'b0;
         boot_cnt <= 8'h00;
         irq_cnt <= 8'hFF;
         a_cnt <= 8'hFF;
         a_ticks <= 8'hFF;
         lo_ticks <= 8'h00;
         gated <= 1'b0;
      end
      else
      begin
         a_q <= ext_interrupt_a_n_i;
         b_q <= ext_interrupt_b_n_i;
         osc_q <= ext_osc_i;
         boot_cnt <= next_boot_cnt;
         irq_cnt <= next_irq_cnt;
         a_cnt <= next_a_cnt;
         a_ticks <= next_a_ticks;
         lo_ticks <= next_lo_ticks;
         gated <= next_gated;
      end
   end

   boot_addr_a: assert property (first_addr_o |-> boot_cnt <= 8'd120)
      else $error("first address too late after reset");
   boot_pll_a: assert property (boot_cnt == 8'd2 |-> !pll_enable_o && pll_bypass_o)
      else $error("multiplier not off and bypassed at reset");
   isr_bound_a: assert property (isr_access_o |-> irq_cnt <= 8'd18)
      else $error("service access too late after interrupt");
   wait_vec_a: assert property (wait_vector_o |-> a_cnt <= 8'd13)
      else $error("wait vector too late");
   stop_gate_a: assert property ($fell(master_clk_en_o) |-> !pll_enable_o && pll_bypass_o)
      else $error("clock gated with multiplier live");
   restart_src_a: assert property ($rose(master_clk_en_o) |-> pll_bypass_o && !pll_enable_o)
      else $error("clock restart not on source clock");
   stop_fetch_a: assert property (stop_fetch_o |-> (gated ? a_ticks <= 8'd25 : a_cnt <= 8'd13))
      else $error("stop fetch too late");
   pins_only_a: assert property (stop_fetch_pins_o |-> stop_fetch_o)
      else $error("pin fetch without stop fetch");
   rst_width_a: assert property ($rose(reset_out_pulse_n_o) |->
      lo_ticks inside {[8'd7:8'd9], [8'd127:8'd129]})
      else $error("reset output width wrong");
   rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside its cycle");

   cover property (stop_fetch_pins_o);
   cover property ($fell(master_clk_en_o));
   cover property (wait_vector_o);
endmodule

// ### verif/testbench.sv
// self-checking bench of the reset, stop and wait sequencer
// assumes the far-side model supplies oscillator, interrupts and reset request
`timescale 1ns/1ns
module testbench;
   import rsw_pkg::*;
   logic sys_clk_i, reset_n_i, reg_write_i, reg_read_i;
   logic [3:0] reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic [15:0] reg_rdata_o;
   logic ext_osc_i, ext_interrupt_a_n_i, ext_interrupt_b_n_i, internal_reset_req_i;
   logic first_addr_o, isr_access_o, wait_vector_o, stop_fetch_o, stop_fetch_pins_o;
   logic pll_enable_o, pll_bypass_o, master_clk_en_o, reset_out_pulse_n_o, irq_o;
   int err_count, num_checks, cyc, n, w;

   rsw_sequencer rsw_sequencer_i (.*);
   rsw_far_model rsw_far_model_i (.sys_clk_i, .ext_osc_o(ext_osc_i), .irq_a_n_o(ext_interrupt_a_n_i),
      .irq_b_n_o(ext_interrupt_b_n_i), .reset_req_o(internal_reset_req_i));

   // ---------------------------------------------------------------
   // clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // a hang counts as a mismatch
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         err_count++;
         conclude();
      end
   end
   task automatic conclude();
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_write_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_read_i <= 1'b0;
      #1 chk(reg_rdata_o & m, exp);
   endtask
   function automatic logic ev(input int s);
      case (s)
         0: return first_addr_o;
         1: return isr_access_o;
         2: return wait_vector_o;
         3: return stop_fetch_o;
         4: return reset_out_pulse_n_o;
         default: return ~reset_out_pulse_n_o;
      endcase
   endfunction
   // counts cycles until the chosen event, bounded
   task automatic wait_ev(input int s, input int lim);
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      while (ev(s) !== 1'b1 && n < lim);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {err_count, num_checks, cyc} = '0;
      {reg_write_i, reg_read_i} = '0;
      reset_n_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      wait_ev(0, 121);
      chk(16'(ev(0)), 16'h0001);
      w = n;
      rd(ADDR_STATE, 16'h0030, 16'h0020);
      wait_ev(4, 600);
      chk(16'(w + n > 500 && w + n < 522), 16'h0001);
      rd(ADDR_STATUS, 16'hFFFF, 16'h0011);
      // refused places and the mode write mask
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'hFFFF, 16'h0000);
      rd(ADDR_CMD, 16'hFFFF, 16'h0000);
      wr(ADDR_MODE, 16'hFFFF);
      rd(ADDR_MODE, 16'hFFFF, 16'h004F);
      rd(ADDR_STATE, 16'h0030, 16'h0010);
      // unmasked then masked service routine
      wr(ADDR_MASK, 16'h0002);
      rsw_far_model_i.edge_irq(1'b1);
      wait_ev(1, 19);
      chk(16'(ev(1)), 16'h0001);
      @(posedge sys_clk_i);
      #1 chk(16'(irq_o), 16'h0001);
      rd(ADDR_STATUS, 16'hFFFF, 16'h0002);
      chk(16'(irq_o), 16'h0000);
      wr(ADDR_MASK, 16'h0000);
      rsw_far_model_i.edge_irq(1'b0);
      wait_ev(1, 19);
      chk(16'(ev(1)), 16'h0001);
      chk(16'(irq_o), 16'h0000);
      rd(ADDR_STATUS, 16'hFFFF, 16'h0002);
      // wait state woken by line a
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_CMD, 16'h0001);
      rsw_far_model_i.edge_irq(1'b0);
      wait_ev(2, 14);
      chk(16'(ev(2)), 16'h0001);
      repeat (30) @(posedge sys_clk_i);
      rd(ADDR_STATUS, 16'h0004, 16'h0004);
      // fast stop in mode 3: clocks untouched, fetch shows on pins
      wr(ADDR_MODE, 16'h0043);
      wr(ADDR_CMD, 16'h0002);
      rd(ADDR_STATE, 16'h007F, 16'h0065);
      rsw_far_model_i.set_a(1'b0);
      wait_ev(3, 14);
      chk(16'(ev(3)), 16'h0001);
      chk(16'(stop_fetch_pins_o), 16'h0001);
      rsw_far_model_i.set_a(1'b1);
      repeat (30) @(posedge sys_clk_i);
      // normal stop in mode 1: clock gated, restart on source clock
      wr(ADDR_MODE, 16'h0001);
      wr(ADDR_CMD, 16'h0002);
      rd(ADDR_STATE, 16'h007F, 16'h0025);
      rsw_far_model_i.set_a(1'b0);
      wait_ev(3, 101);
      chk(16'(ev(3)), 16'h0001);
      chk(16'(stop_fetch_pins_o), 16'h0000);
      rsw_far_model_i.set_a(1'b1);
      rd(ADDR_STATE, 16'h0070, 16'h0060);
      rd(ADDR_STATUS, 16'h0008, 16'h0008);
      // short reset output in internal reset mode
      wr(ADDR_MODE, 16'h0004);
      rsw_far_model_i.pulse_rst();
      wait_ev(5, 4);
      wait_ev(4, 40);
      chk(16'(n > 27 && n < 37), 16'h0001);
      conclude();
   end
endmodule

bind rsw_sequencer rsw_sequencer_chk rsw_sequencer_chk_i (.sys_clk_i, .reset_n_i, .ext_osc_i,
   .ext_interrupt_a_n_i, .ext_interrupt_b_n_i, .internal_reset_req_i, .reg_read_i, .reg_rdata_o,
   .first_addr_o, .isr_access_o, .wait_vector_o, .stop_fetch_o, .stop_fetch_pins_o, .pll_enable_o,
   .pll_bypass_o, .master_clk_en_o, .reset_out_pulse_n_o);
